// [core/asm_map.v]
// Address decode and pin sharing between the core, internal modules
// and the external multiplexed bus.
// Assumes one clock; core requests are held until acknowledged.
`include "asm_defines.vh"
module asm_map #(
    parameter IMPL_MASK = 16'h0000 // Implemented register sub-blocks
) (
    input wire clock,                       // System clock
    input wire sys_rst,                     // Synchronous reset
    input wire cfg_boot_rom,                // Boot ROM strap
    input wire module_map_select,           // Register block location
    input wire bus_mode_en,                 // Pins run the external bus
    input wire [`ASM_CORE_AW-1:0] core_addr, // Core address
    input wire core_req,                    // Core access request
    input wire core_wr,                     // Core write
    input wire [`ASM_DW-1:0] core_wdata,    // Core write data
    output reg [`ASM_DW-1:0] core_rdata,    // Read data
    output wire core_ack,                   // Access done
    output reg core_fault,                  // Blocked address seen
    output wire [`ASM_BUS_AW-1:0] intermodule_bus_addr, // Bus address
    output wire int_sel,                    // Internal module selected
    input wire [`ASM_DW-1:0] int_rdata,     // Internal module read data
    input wire int_ack,                     // Internal module done
    output wire ext_req,                    // External access request
    input wire ext_ack,                     // External access done
    input wire [`ASM_DW-1:0] ext_rdata,     // External read data
    output reg [`ASM_EXT_AW-1:0] pin_addr_o, // Address pins
    output reg [`ASM_EXT_AW-1:0] pin_addr_oe, // Address pin enables
    input wire [`ASM_EXT_AW-1:0] pin_addr_i, // Address pin inputs
    input wire [7:0] port_a_bits,           // Port A output data
    input wire [7:0] port_b_bits,           // Port B output data
    input wire [1:0] port_c_low_bits,       // Port C output data
    input wire [`ASM_EXT_AW-1:0] port_dir,  // Port direction, 1 = out
    output wire [`ASM_EXT_AW-1:0] port_in,  // Port input value
    output reg boot_rom_vis                 // Boot ROM in map
);
    // ----------------------------------------------------------------
    // Local sizes and read source codes
    // ----------------------------------------------------------------
    localparam ROM_WORDS = `ASM_ROM_BYTES / 2;
    localparam [3:0] SRC_NONE = 4'h1;
    localparam [3:0] SRC_INT = 4'h2;
    localparam [3:0] SRC_ROM = 4'h4;
    localparam [3:0] SRC_EXT = 4'h8;

    // ----------------------------------------------------------------
    // Address extension and decode
    // ----------------------------------------------------------------
    wire [`ASM_BUS_AW-1:0] baddr;
    wire hole;
    wire in_regs;
    wire in_rom;
    wire in_ram;
    wire sub_impl;
    wire go_int;

    assign baddr = {{4{core_addr[`ASM_CORE_AW-1]}}, core_addr};
    assign intermodule_bus_addr = baddr;

    function in_range;
        input [`ASM_BUS_AW-1:0] a;
        input [`ASM_BUS_AW-1:0] lo;
        input [`ASM_BUS_AW-1:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    // Register block: top nibble {map bit, 111}, bits 19:12 all ones
    function reg_hit;
        input sel;
        input [`ASM_BUS_AW-1:0] a;
        begin
            reg_hit = (a[23:20] == {sel, `ASM_REG_NIB_LO}) &&
                      (a[19:`ASM_REG_BLK_AW] == `ASM_REG_TAG);
        end
    endfunction

    // Copying bit 19 upwards keeps every core address out of the hole;
    // the decode still guards the full bus width
    assign hole = in_range(baddr, `ASM_HOLE_LO, `ASM_HOLE_HI);
    assign in_regs = reg_hit(module_map_select, baddr);
    assign sub_impl = IMPL_MASK[baddr[11:8]];
    assign in_rom = boot_rom_vis &&
                    in_range(baddr, `ASM_ROM_BASE, `ASM_ROM_LAST);
    assign in_ram = 1'b0;
    assign go_int = (in_regs && sub_impl) || in_rom || in_ram;

    // ----------------------------------------------------------------
    // Boot configuration capture
    // ----------------------------------------------------------------
    always @(posedge clock) begin
        if (sys_rst) begin
            boot_rom_vis <= cfg_boot_rom;
        end
    end

    // ----------------------------------------------------------------
    // Boot ROM contents
    // ----------------------------------------------------------------
    // Boot ROM words; contents are all zero in this block
    reg [`ASM_DW-1:0] rom [0:ROM_WORDS-1];
    integer i;
    initial begin
        for (i = 0; i < ROM_WORDS; i = i + 1) begin
            rom[i] = {`ASM_DW{1'b0}};
        end
    end

    // ----------------------------------------------------------------
    // Request qualification and acknowledge
    // ----------------------------------------------------------------
    wire active;
    assign active = core_req && !hole && !sys_rst;
    assign int_sel = active && in_regs && sub_impl;
    assign ext_req = active && !go_int && bus_mode_en;
    wire ack_hole;
    wire ack_int;
    wire ack_rom;
    wire ack_ext;
    wire ack_nobus;

    // Hole, ROM and bus-less accesses finish in the cycle they are made
    assign ack_hole = core_req && hole;
    assign ack_int = int_sel && int_ack;
    assign ack_rom = active && in_rom;
    assign ack_ext = ext_req && ext_ack;
    assign ack_nobus = active && !go_int && !bus_mode_en;
    assign core_ack = ack_hole || ack_int || ack_rom || ack_ext ||
                      ack_nobus;

    // ----------------------------------------------------------------
    // Read data capture
    // ----------------------------------------------------------------
    reg [3:0] src_nxt;
    reg [`ASM_DW-1:0] rdata_nxt;

    // One source per access; hole requests read back zero
    always @* begin
        if (hole) begin
            src_nxt = SRC_NONE;
        end else if (int_sel) begin
            src_nxt = SRC_INT;
        end else if (in_rom) begin
            src_nxt = SRC_ROM;
        end else begin
            src_nxt = SRC_EXT;
        end
    end

    always @* begin
        case (src_nxt)
            SRC_INT: begin
                rdata_nxt = int_rdata;
            end
            SRC_ROM: begin
                rdata_nxt = rom[baddr[8:1]];
            end
            SRC_EXT: begin
                rdata_nxt = ext_rdata;
            end
            default: begin
                rdata_nxt = {`ASM_DW{1'b0}};
            end
        endcase
    end

    // Captured on every requesting edge, so the acknowledge edge wins
    always @(posedge clock) begin
        if (sys_rst) begin
            core_rdata <= 16'h0000;
            core_fault <= 1'b0;
        end else if (core_req) begin
            core_fault <= hole;
            core_rdata <= rdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Pin sharing between bus and ports
    // ----------------------------------------------------------------
    wire [`ASM_EXT_AW-1:0] port_out;
    assign port_out = {port_c_low_bits, port_a_bits, port_b_bits};

    reg [`ASM_EXT_AW-1:0] pin_o_nxt;
    reg [`ASM_EXT_AW-1:0] pin_oe_nxt;

    // Bus mode drives the address pins only while an external access
    // is requested; port mode lets each bit follow its direction
    always @* begin
        if (bus_mode_en) begin
            pin_o_nxt = baddr[`ASM_EXT_AW-1:0];
            pin_oe_nxt = {`ASM_EXT_AW{ext_req}};
        end else begin
            pin_o_nxt = port_out;
            pin_oe_nxt = port_dir;
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            pin_addr_o <= 18'h0_0000;
            pin_addr_oe <= 18'h0_0000;
        end else begin
            pin_addr_o <= pin_o_nxt;
            pin_addr_oe <= pin_oe_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Port inputs
    // ----------------------------------------------------------------
    asm_sync #(
        .W(`ASM_EXT_AW)
    ) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .din(pin_addr_i),
        .sync_en(!bus_mode_en),
        .dout(port_in)
    );

    // Writes carry no data path in this block
    wire unused_wdata;
    assign unused_wdata = ^{core_wdata, core_wr};
endmodule

// [shared/asm_defines.vh]
// Constants for the address-space map block.
// Assumes a single 250 MHz clock and a synchronous active-high reset.
//
// Summary of operation
// - Bus address bits 23:20 copy core address bit 19.
// - Core supplies 20 address and 16 data bits to a 24-bit bus.
// - Addresses 080000 to F7FFFF are never accessed.
// - Only address bits 17:0 leave the chip.
// - Accesses to unimplemented internal blocks go to the external bus.
// - Register block sits where the top nibble is the map bit then 111.
// - Boot ROM visibility is fixed by configuration caught during reset.
// - Bus pins not used for the bus act as ports A, B and C.
// - Marked inputs pass a synchroniser only while used as port pins.
`ifndef ASM_DEFINES_VH
`define ASM_DEFINES_VH

`define ASM_CORE_AW 20
`define ASM_BUS_AW 24
`define ASM_DW 16
`define ASM_EXT_AW 18
`define ASM_HOLE_LO 24'h08_0000
`define ASM_HOLE_HI 24'hF7_FFFF
`define ASM_REG_NIB_LO 3'b111
`define ASM_REG_BLK_AW 12
`define ASM_REG_TAG 8'hFF
`define ASM_ROM_LAST 24'h00_01FF
`define ASM_ROM_BYTES 512
`define ASM_ROM_BASE 24'h00_0000
`define ASM_RAM_AW 11

`endif

// [core/asm_sync.v]
// Two-stage synchroniser with a bypass for pins not used as port pins.
// Assumes one clock and a synchronous active-high reset.
module asm_sync #(
    parameter W = 8
) (
    input wire clock,           // System clock
    input wire sys_rst,         // Synchronous reset
    input wire [W-1:0] din,     // Raw pin input
    input wire sync_en,         // High while pin acts as port I/O
    output wire [W-1:0] dout    // Conditioned input
);
    reg [W-1:0] meta_r;
    reg [W-1:0] stab_r;

    always @(posedge clock) begin
        if (sys_rst) begin
            meta_r <= {W{1'b0}};
            stab_r <= {W{1'b0}};
        end else begin
            meta_r <= din;
            stab_r <= meta_r;
        end
    end

    assign dout = sync_en ? stab_r : din;
endmodule

// [tb/asm_map_monitor.sv]
// Checker on the address map ports.
// Assumes the bind passes the design's IMPL_MASK.
module asm_map_monitor #(
    parameter logic [15:0] IMPL_MASK = 16'h0000 // Implemented sub-blocks
) (
    input wire clock, // Clock
    input wire module_map_select, int_sel, // Decode
    input wire sys_rst, // Reset
    input wire cfg_boot_rom, bus_mode_en, boot_rom_vis, // Mode
    input wire core_req, core_ack, ext_req, ext_ack, // Handshake
    input wire [19:0] core_addr, // Core address
    input wire [23:0] intermodule_bus_addr, // Bus address
    input wire [17:0] pin_addr_o, pin_addr_i, port_in, // Pins
    input wire [7:0] port_a_bits, port_b_bits, // Ports
    input wire [1:0] port_c_low_bits // Port C
);
    timeunit 1ns;
    timeprecision 1ps;
    wire rom_hit = boot_rom_vis && core_addr[19:9] == 11'h000;
    wire reg_hit = module_map_select && core_addr[19:12] == 8'hFF &&
        IMPL_MASK[core_addr[11:8]];
    default clocking @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    a_top_extend: assert property (intermodule_bus_addr ==
        {{4{core_addr[19]}}, core_addr}) else $error("upper bits");
    a_hole_skip: assert property (core_req |->
        intermodule_bus_addr[23:19] inside {5'h00, 5'h1F}) else $error("hole");
    a_pin_addr: assert property (ext_req && ext_ack |=>
        pin_addr_o == $past(core_addr[17:0])) else $error("pins");
    a_route_out: assert property (core_req && bus_mode_en &&
        !rom_hit && !reg_hit |-> ext_req) else $error("route");
    a_reg_route: assert property (core_req && reg_hit |->
        int_sel && !ext_req) else $error("reg route");
    a_reg_only: assert property (int_sel |-> reg_hit)
        else $error("reg only");
    a_rom_local: assert property (core_req && rom_hit |->
        core_ack && !ext_req) else $error("rom");
    a_rom_strap: assert property (disable iff (1'b0) sys_rst |=>
        boot_rom_vis == $past(cfg_boot_rom)) else $error("strap");
    a_port_out: assert property (!bus_mode_en |=> pin_addr_o ==
        $past({port_c_low_bits, port_a_bits, port_b_bits})) else $error("port");
    a_raw_in: assert property (bus_mode_en |->
        port_in == pin_addr_i) else $error("bypass");
endmodule
bind asm_map asm_map_monitor #(.IMPL_MASK(IMPL_MASK)) mon (.*);

// [tb/asm_ext_model.sv]
// External bus memory model.
// Assumes requests are held until acknowledged.
module asm_ext_model (
    input wire clock, // Clock
    input wire ext_req, // Request
    input wire [23:0] addr, // Bus address
    input wire [3:0] lag, // Wait cycles
    output reg ext_ack = 1'b0, // Done
    output wire [15:0] ext_rdata // Read data
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [3:0] cnt_r = 4'h0;
    wire [15:0] word = addr[15:0] ^ 16'hA5A5;
    // Inverted outside the ack cycle so stale data never matches
    assign ext_rdata = ext_ack ? word : ~word;
    always @(posedge clock) begin
        cnt_r <= (ext_req && !ext_ack) ? cnt_r + 4'h1 : 4'h0;
        ext_ack <= ext_req && !ext_ack && cnt_r == lag;
    end
endmodule

// [tb/asm_map_tb.sv]
// Bench: external reads, boot ROM, port pins.
// Assumes the model answers lag+1 cycles after a request.
module asm_map_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, sys_rst = 1, cfg_boot_rom = 1, module_map_select = 0;
    logic bus_mode_en = 1, core_req = 0, core_wr = 0, int_ack = 0;
    logic core_ack, core_fault, int_sel, ext_req, ext_ack, boot_rom_vis;
    logic [19:0] core_addr = '0;
    logic [15:0] core_wdata = '0, int_rdata = 16'h3C5A;
    logic [15:0] core_rdata, ext_rdata;
    logic [23:0] intermodule_bus_addr;
    logic [17:0] pin_addr_o, pin_addr_oe, port_in, pin_addr_i = '0;
    logic [17:0] port_dir = '0;
    logic [7:0] port_a_bits = '0, port_b_bits = '0;
    logic [1:0] port_c_low_bits = '0;
    logic [3:0] lag = '0;
    logic [19:0] tab [3] = '{20'h7_F000, 20'hF_F010, 20'h8_1234};
    int n_errors = 0, tests_run = 0;
    asm_map #(.IMPL_MASK(16'h0002)) dut (.*);
    // Internal module: answers one cycle after it is selected
    always @(posedge clock) int_ack <= int_sel && !int_ack;
    asm_ext_model ext (.clock(clock), .ext_req(ext_req), .ext_ack(ext_ack),
        .addr(intermodule_bus_addr), .lag(lag), .ext_rdata(ext_rdata));
    always #2 clock = ~clock;
    task check(input string what, input logic [23:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task conclude;
        $display("%0d checks, %0d mismatches", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task access(input logic [19:0] a);
        tick(1);
        core_addr = a;
        core_req = 1;
        for (int i = 0; i <= 20; i++) begin
            @(negedge clock);
            if (core_ack === 1'b1) break;
            if (i == 20) begin
                n_errors++;
                conclude;
            end
        end
        tick(1);
        core_req = 0;
    endtask
    task t_ext;
        foreach (tab[i]) begin
            module_map_select = i[0];
            lag = 4'(i * 3);
            access(tab[i]);
            check("rdata", tab[i][15:0] ^ 16'hA5A5, core_rdata);
            check("bus", {{4{tab[i][19]}}, tab[i]}, intermodule_bus_addr);
            check("pins", tab[i][17:0], pin_addr_o);
            check("fault", 0, core_fault);
        end
        $display("external test done");
    endtask
    task t_rom;
        access(20'h0_0010);
        check("rom", 0, core_rdata);
        cfg_boot_rom = 0;
        sys_rst = 1;
        tick(4);
        sys_rst = 0;
        cfg_boot_rom = 1;
        access(20'h0_0010);
        check("no rom", 16'hA5B5, core_rdata);
        check("rom vis", 0, boot_rom_vis);
        $display("rom test done");
    endtask
    task t_regs;
        lag = 4'h1;
        module_map_select = 1;
        access(20'hF_F100);
        check("reg", 16'h3C5A, core_rdata);
        module_map_select = 0;
        access(20'hF_F100);
        check("reg moved", 16'hF100 ^ 16'hA5A5, core_rdata);
        $display("register test done");
    endtask
    task t_ports;
        bus_mode_en = 0;
        {port_c_low_bits, port_a_bits, port_b_bits} = 18'h2_5A3C;
        port_dir = 18'h3_F00F;
        pin_addr_i = 18'h1_C3A5;
        tick(1);
        check("port out", 18'h2_5A3C, pin_addr_o);
        check("port dir", 18'h3_F00F, pin_addr_oe);
        check("sync 1", 0, port_in);
        tick(1);
        check("sync 2", 18'h1_C3A5, port_in);
        $display("port test done");
    endtask
    initial begin
        tick(4);
        sys_rst = 0;
        t_ext;
        t_rom;
        t_regs;
        t_ports;
        conclude;
    end
endmodule
